// ===== rtl/pmt_table_access.sv
// Program memory with table read, table write, block program and block erase.
`timescale 1ns/1ps

// How it works
// - Byte addressed memory, counter steps by two.
// - Table read moves one byte to latch.
// - Long write programs one eight-byte block.
// - Erase clears one 64-byte block.
// - Bulk erase from running code is refused.
// - Fetch stalls while write or erase runs.
// - Internal timer ends every write and erase.
// - Lone second words execute as no-operation.
// - Table write fills one holding register only.
// - Table data may sit at any byte.
// - Eight holding loads, then control write starts.
// - Holding registers reset to FFh after operations.
// - Programming only clears bits; FFh keeps byte.
module pmt_table_access #(
  parameter int unsigned PROG_CYCLES = pmt_pkg::PROG_CYCLES
) (
  // Clock and reset.
  input  wire logic                       clk_in,
  input  wire logic                       nrst_in,
  // Table pointer and latch access from the core.
  input  wire logic [pmt_pkg::ADDR_W-1:0] table_pointer_in,
  input  wire logic                       latch_wr_in,
  input  wire logic [7:0]                 latch_wdata_in,
  output logic      [7:0]                 table_latch_out,
  // Table operations.
  input  wire logic                       table_read_op_in,
  input  wire logic                       table_write_op_in,
  // Control register.
  input  wire logic                       ctrl_wr_in,
  input  wire logic [7:0]                 ctrl_wdata_in,
  output logic      [7:0]                 ctrl_rdata_out,
  // Instruction fetch.
  input  wire logic                       fetch_req_in,
  input  wire logic                       pc_load_in,
  input  wire logic [pmt_pkg::ADDR_W-2:0] pc_word_in,
  output logic      [pmt_pkg::ADDR_W-1:0] pc_out,
  output logic      [15:0]                instr_out,
  output logic                            instr_valid_out,
  output logic                            fetch_stall_out
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0]                 mem [pmt_pkg::PMEM_BYTES];
  logic [7:0]                 hold [pmt_pkg::HOLD_N];
  logic [7:0]                 table_latch;
  logic [pmt_pkg::ADDR_W-1:0] pc;
  logic [15:0]                instr;
  logic                       instr_valid;
  logic                       prev_first;
  logic                       refused;
  logic                       wren;
  logic                       erase_sel;
  logic [pmt_pkg::CNT_W-1:0]  count;
  logic [pmt_pkg::ADDR_W-1:0] op_addr;
  pmt_pkg::pmt_state_e        state;
  pmt_pkg::pmt_state_e        next_state;

  // Recognises the first word of a two-word instruction.
  function automatic logic is_first_word(input logic [15:0] w);
    is_first_word = (w[15:12] == 4'hc) || (w[15:9] == 7'b1110_110) ||
                    (w[15:8] == 8'hef) || (w[15:4] == 12'hee0);
  endfunction : is_first_word

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Any byte address is legal for table access; alignment is the caller's concern.
  wire logic        busy       = (state != pmt_pkg::PMT_IDLE);
  wire logic        rd_go      = table_read_op_in && !busy;
  wire logic        wr_go      = table_write_op_in && !busy;
  wire logic [pmt_pkg::HOLD_IDX_W-1:0] hold_idx =
                               table_pointer_in[pmt_pkg::HOLD_IDX_W-1:0];
  wire logic [7:0]  rd_byte    = mem[table_pointer_in];
  wire logic        start_req  = ctrl_wr_in && !busy && ctrl_wdata_in[pmt_pkg::CTL_START];
  wire logic        ctl_wren   = ctrl_wdata_in[pmt_pkg::CTL_WREN];
  wire logic        bulk_req   = start_req && ctrl_wdata_in[pmt_pkg::CTL_BULK];
  wire logic        start_ok   = start_req && !bulk_req && ctl_wren;
  wire logic        timer_done = busy && (count == '0);
  wire logic        fetch_go   = fetch_req_in && !busy;
  wire logic [pmt_pkg::ADDR_W-1:0] pc_hi = pc + 13'h0001;
  wire logic [15:0] raw_word   = {mem[pc_hi], mem[pc]};
  // A lone second word (top nibble all ones) is executed as a no-operation.
  wire logic        lone_tail  = (raw_word[15:12] == 4'hf) && !prev_first;
  wire logic [15:0] dec_word   = lone_tail ? pmt_pkg::NOP_WORD : raw_word;

  // Outputs are flip-flop bits; only the busy decode, on the stall and status bit 7, is combinational.
  assign table_latch_out = table_latch;
  assign pc_out          = pc;
  assign instr_out       = instr;
  assign instr_valid_out = instr_valid;
  assign fetch_stall_out = busy;
  assign ctrl_rdata_out  = {busy, refused, erase_sel, 1'b0, wren, 3'b000};

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      pmt_pkg::PMT_IDLE: begin
        if (start_ok) begin
          next_state = ctrl_wdata_in[pmt_pkg::CTL_ERASE] ? pmt_pkg::PMT_ERASE
                                                         : pmt_pkg::PMT_WRITE;
        end
      end
      pmt_pkg::PMT_WRITE,
      pmt_pkg::PMT_ERASE: begin
        if (timer_done) begin
          next_state = pmt_pkg::PMT_IDLE;
        end
      end
      default: begin
        next_state = pmt_pkg::PMT_IDLE;
      end
    endcase
  end

  // State, timer and captured operation address.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state   <= pmt_pkg::PMT_IDLE;
      count   <= '0;
      op_addr <= '0;
    end else begin
      state <= next_state;
      if (start_ok) begin
        count   <= PROG_CYCLES[pmt_pkg::CNT_W-1:0] - 20'h00001;
        op_addr <= table_pointer_in;
      end else if (busy && count != '0) begin
        count <= count - 20'h00001;
      end
    end
  end

  // Control flags; a new refusal wins over the clear by a control write.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      refused   <= 1'b0;
      wren      <= 1'b0;
      erase_sel <= 1'b0;
    end else if (ctrl_wr_in && !busy) begin
      refused   <= bulk_req;
      wren      <= ctl_wren;
      erase_sel <= ctrl_wdata_in[pmt_pkg::CTL_ERASE];
    end
  end

  // ---------------------------------------------------------------
  // Table latch and holding registers
  // ---------------------------------------------------------------
  // A core write to the latch in the same cycle as a table read loses to the read.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      table_latch <= '0;
    end else if (rd_go) begin
      table_latch <= rd_byte;
    end else if (latch_wr_in) begin
      table_latch <= latch_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < pmt_pkg::HOLD_N; i++) begin
        hold[i] <= pmt_pkg::BLANK_BYTE;
      end
    end else if (timer_done) begin
      for (int i = 0; i < pmt_pkg::HOLD_N; i++) begin
        hold[i] <= pmt_pkg::BLANK_BYTE;
      end
    end else if (wr_go) begin
      hold[hold_idx] <= table_latch;
    end
  end

  // ---------------------------------------------------------------
  // Flash array
  // ---------------------------------------------------------------
  // The array is committed only when the timer expires; a reset abandons the
  // operation and sets every byte of the array back to FFh, old contents included.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < pmt_pkg::PMEM_BYTES; i++) begin
        mem[i] <= pmt_pkg::BLANK_BYTE;
      end
    end else if (timer_done && state == pmt_pkg::PMT_WRITE) begin
      for (int i = 0; i < pmt_pkg::HOLD_N; i++) begin
        mem[{op_addr[pmt_pkg::ADDR_W-1:pmt_pkg::HOLD_IDX_W], 3'(i)}] <=
          mem[{op_addr[pmt_pkg::ADDR_W-1:pmt_pkg::HOLD_IDX_W], 3'(i)}] & hold[i];
      end
    end else if (timer_done && state == pmt_pkg::PMT_ERASE) begin
      for (int i = 0; i < pmt_pkg::ERASE_N; i++) begin
        mem[{op_addr[pmt_pkg::ADDR_W-1:pmt_pkg::ERASE_IDX_W], 6'(i)}] <=
          pmt_pkg::BLANK_BYTE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Instruction fetch
  // ---------------------------------------------------------------
  // A load wins over a fetch in the same cycle; bit zero is never stored as one.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc          <= '0;
      instr       <= pmt_pkg::NOP_WORD;
      instr_valid <= 1'b0;
      prev_first  <= 1'b0;
    end else if (pc_load_in) begin
      pc          <= {pc_word_in, 1'b0};
      instr_valid <= 1'b0;
      prev_first  <= 1'b0;
    end else if (fetch_go) begin
      pc          <= pc + 13'h0002;
      instr       <= dec_word;
      instr_valid <= 1'b1;
      prev_first  <= is_first_word(raw_word);
    end else begin
      instr_valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_pc_even;
    @(posedge clk_in) disable iff (!nrst_in) pc_out[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("pc odd");

  property p_pc_step;
    @(posedge clk_in) disable iff (!nrst_in)
      (fetch_req_in && !fetch_stall_out && !pc_load_in) |=>
        (pc_out == $past(pc_out) + 13'h0002) && instr_valid_out;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");

  property p_rd_latch;
    @(posedge clk_in) disable iff (!nrst_in)
      (table_read_op_in && !fetch_stall_out) |=> table_latch_out == $past(rd_byte);
  endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("read byte lost");

  property p_wr_hold;
    @(posedge clk_in) disable iff (!nrst_in)
      (table_write_op_in && !fetch_stall_out) |=>
        (hold[$past(hold_idx)] == $past(table_latch_out)) && !fetch_stall_out;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("hold load wrong");

  property p_stall;
    @(posedge clk_in) disable iff (!nrst_in)
      fetch_stall_out |=> !instr_valid_out && (pc_out == $past(pc_out) || $past(pc_load_in));
  endproperty
  a_stall: assert property (p_stall) else $error("fetch during busy");

  // Length of the current busy run. A counter rather than a delay range,
  // because the real programming time is far longer than a range may span.
  logic [pmt_pkg::CNT_W-1:0] busy_run;
  wire logic [pmt_pkg::CNT_W-1:0] last_run = PROG_CYCLES[pmt_pkg::CNT_W-1:0] - 20'h00001;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_run <= '0;
    end else if (busy) begin
      busy_run <= busy_run + 20'h00001;
    end else begin
      busy_run <= '0;
    end
  end

  property p_timer_end;
    @(posedge clk_in) disable iff (!nrst_in)
      busy |-> (busy_run <= last_run);
  endproperty
  a_timer_end: assert property (p_timer_end) else $error("timer end");

  property p_timer_exact;
    @(posedge clk_in) disable iff (!nrst_in)
      $fell(fetch_stall_out) |-> ($past(busy_run) == last_run);
  endproperty
  a_timer_exact: assert property (p_timer_exact) else $error("timer length");

  property p_bulk;
    @(posedge clk_in) disable iff (!nrst_in)
      bulk_req |=> !fetch_stall_out && ctrl_rdata_out[pmt_pkg::STS_REFUSE];
  endproperty
  a_bulk: assert property (p_bulk) else $error("bulk erase not refused");

  property p_hold_blank;
    @(posedge clk_in) disable iff (!nrst_in)
      timer_done |=> (hold[0] == 8'hff) && (hold[7] == 8'hff) && !busy;
  endproperty
  a_hold_blank: assert property (p_hold_blank) else $error("hold not blank");

  property p_clear_only;
    @(posedge clk_in) disable iff (!nrst_in)
      (timer_done && state == pmt_pkg::PMT_WRITE) |=>
        mem[{op_addr[12:3], 3'h0}] == ($past(mem[{op_addr[12:3], 3'h0}]) & $past(hold[0]));
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("program set a bit");

  property p_erase_blank;
    @(posedge clk_in) disable iff (!nrst_in)
      (timer_done && state == pmt_pkg::PMT_ERASE) |=>
        mem[{op_addr[12:6], 6'h3f}] == 8'hff;
  endproperty
  a_erase_blank: assert property (p_erase_blank) else $error("erase incomplete");

  property p_nop;
    @(posedge clk_in) disable iff (!nrst_in)
      (fetch_go && !pc_load_in && lone_tail) |=> instr_out == 16'h0000;
  endproperty
  a_nop: assert property (p_nop) else $error("lone tail not nop");

endmodule : pmt_table_access

// ===== rtl/pmt_pkg.sv
// Constants shared by the program memory table access block.
package pmt_pkg;

  // ---------------------------------------------------------------
  // Memory geometry
  // ---------------------------------------------------------------
  localparam int unsigned PMEM_BYTES = 8192;
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned HOLD_N     = 8;
  localparam int unsigned ERASE_N    = 64;
  localparam int unsigned HOLD_IDX_W = 3;
  localparam int unsigned ERASE_IDX_W = 6;
  localparam logic [7:0]  BLANK_BYTE = 8'hff;
  localparam logic [15:0] NOP_WORD   = 16'h0000;

  // ---------------------------------------------------------------
  // Control register field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTL_START  = 0;
  localparam int unsigned CTL_ERASE  = 1;
  localparam int unsigned CTL_BULK   = 2;
  localparam int unsigned CTL_WREN   = 3;
  localparam int unsigned STS_BUSY   = 7;
  localparam int unsigned STS_REFUSE = 6;
  localparam int unsigned STS_ERASE  = 5;
  localparam int unsigned STS_WREN   = 3;

  // ---------------------------------------------------------------
  // Programming timer
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PROG_TIME_NS  = 2000000;
  localparam int unsigned PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 20;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PMT_IDLE  = 2'b00,
    PMT_WRITE = 2'b01,
    PMT_ERASE = 2'b10
  } pmt_state_e;

endpackage : pmt_pkg

// ===== tb/pmt_core_model.sv
// Behavioural processor core that issues table, control and fetch requests.
`timescale 1ns/1ps
module pmt_core_model (
  // Clock.
  input  wire logic                       clk_in,
  // Table and control requests.
  output logic      [pmt_pkg::ADDR_W-1:0] table_pointer_out,
  output logic                            latch_wr_out,
  output logic      [7:0]                 latch_wdata_out,
  output logic                            table_read_op_out,
  output logic                            table_write_op_out,
  output logic                            ctrl_wr_out,
  output logic      [7:0]                 ctrl_wdata_out,
  // Instruction fetch requests.
  output logic                            fetch_req_out,
  output logic                            pc_load_out,
  output logic      [pmt_pkg::ADDR_W-2:0] pc_word_out
);
  // ---------------------------------------------------------------
  // Request drivers
  // ---------------------------------------------------------------
  // Everything idles at time zero.
  initial begin
    {latch_wr_out, table_read_op_out, table_write_op_out, ctrl_wr_out} = 4'h0;
    {fetch_req_out, pc_load_out} = 2'b00;
    table_pointer_out = '0;
    latch_wdata_out   = 8'h00;
    ctrl_wdata_out    = 8'h00;
    pc_word_out       = '0;
  end

  // One strobe for one cycle; data is inverted once released so stale values never pass.
  task automatic issue(input logic [3:0] sel, input logic [12:0] ptr, input logic [7:0] d);
    @(posedge clk_in);
    table_pointer_out <= ptr;
    latch_wdata_out   <= d;
    ctrl_wdata_out    <= d;
    {latch_wr_out, table_read_op_out, table_write_op_out, ctrl_wr_out} <= sel;
    @(posedge clk_in);
    {latch_wr_out, table_read_op_out, table_write_op_out, ctrl_wr_out} <= 4'h0;
    latch_wdata_out   <= ~d;
    ctrl_wdata_out    <= ~d;
  endtask : issue

  // A counter load when ld is high, otherwise one fetch request.
  task automatic fetch(input logic ld, input logic [11:0] w);
    @(posedge clk_in);
    pc_word_out   <= w;
    pc_load_out   <= ld;
    fetch_req_out <= !ld;
    @(posedge clk_in);
    pc_load_out   <= 1'b0;
    fetch_req_out <= 1'b0;
    pc_word_out   <= ~w;
  endtask : fetch
endmodule : pmt_core_model

// ===== tb/program_memory_table_access_tb_top.sv
// Self-checking testbench for the program memory table access block.
`timescale 1ns/1ps
module program_memory_table_access_tb_top;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  // A short programming time keeps the run brief; the expected busy cycle counts derive from it.
  localparam int PROG = 12;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [12:0] ptr;
  logic        lwr, rdop, wrop, cwr, freq, pld;
  logic [7:0]  lwd, cwd, latch, sts;
  logic [11:0] pcw;
  logic [12:0] pc;
  logic [15:0] instr;
  logic        valid, stall;
  int          fails = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [7:0]  blk [8] = '{8'h55, 8'h0f, 8'h56, 8'hf4, 8'h23, 8'hc1, 8'h56, 8'hf4};

  pmt_table_access #(.PROG_CYCLES(PROG)) pmt_table_access_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .table_pointer_in(ptr), .latch_wr_in(lwr),
    .latch_wdata_in(lwd), .table_latch_out(latch), .table_read_op_in(rdop),
    .table_write_op_in(wrop), .ctrl_wr_in(cwr), .ctrl_wdata_in(cwd), .ctrl_rdata_out(sts),
    .fetch_req_in(freq), .pc_load_in(pld), .pc_word_in(pcw), .pc_out(pc),
    .instr_out(instr), .instr_valid_out(valid), .fetch_stall_out(stall));

  pmt_core_model pmt_core_model_inst (
    .clk_in(clk_in), .table_pointer_out(ptr), .latch_wr_out(lwr), .latch_wdata_out(lwd),
    .table_read_op_out(rdop), .table_write_op_out(wrop), .ctrl_wr_out(cwr),
    .ctrl_wdata_out(cwd), .fetch_req_out(freq), .pc_load_out(pld), .pc_word_out(pcw));

  // Clock and a cycle count used to time the long operations.
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic op(input logic [3:0] sel, input logic [12:0] p, input logic [7:0] d);
    pmt_core_model_inst.issue(sel, p, d);
  endtask : op

  task automatic rd_check(input logic [12:0] p, input logic [7:0] e);
    op(4'h4, p, 8'h00);
    #1;
    check("table latch", {8'h00, e}, {8'h00, latch});
  endtask : rd_check

  task automatic fetch_check(input logic [15:0] e, input logic [12:0] epc);
    pmt_core_model_inst.fetch(1'b0, 12'h000);
    #1;
    check("fetch valid", 16'h0001, {15'h0, valid});
    check("instruction", e, instr);
    check("program counter", {3'h0, epc}, {3'h0, pc});
  endtask : fetch_check

  // Control write; while busy, a read and a fetch must both be turned away.
  task automatic run_ctrl(input logic [7:0] d, input logic [12:0] p, input logic [7:0] es,
                          input int dur);
    int t0;
    int guard;
    op(4'h8, p, 8'h3c);
    op(4'h1, p, d);
    #1;
    t0 = cyc;
    guard = 0;
    check("status", {8'h00, es}, {8'h00, sts});
    check("stall", {15'h0, dur != 0}, {15'h0, stall});
    if (dur != 0) begin
      op(4'h4, p, 8'h00);
      #1;
      check("latch while busy", 16'h003c, {8'h00, latch});
      pmt_core_model_inst.fetch(1'b0, 12'h000);
      #1;
      check("valid while busy", 16'h0000, {15'h0, valid});
      while (stall === 1'b1 && guard < 200) begin
        @(posedge clk_in);
        #1;
        guard++;
      end
      check("busy cycles", 16'(dur), 16'(cyc - t0));
    end
  endtask : run_ctrl

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    check("pc after reset", 16'h0000, {3'h0, pc});
    check("stall after reset", 16'h0000, {15'h0, stall});
    rd_check(13'h0141, 8'hff);
    $display("Test reset done");
  endtask : t_reset

  // Holding registers loaded in reverse order, then one 8-byte block programmed.
  task automatic t_program;
    for (int i = 7; i >= 0; i--) begin
      op(4'h8, 13'h0140 + 13'(i), blk[i]);
      op(4'h2, 13'h0140 + 13'(i), 8'h00);
    end
    rd_check(13'h0143, 8'hff);
    run_ctrl(8'h09, 13'h0140, 8'h88, PROG);
    for (int i = 0; i < 8; i++) begin
      rd_check(13'h0140 + 13'(i), blk[i]);
    end
    rd_check(13'h0148, 8'hff);
    rd_check(13'h013f, 8'hff);
    $display("Test program done");
  endtask : t_program

  // Word fetches, including a lone second word that must become a no-operation.
  task automatic t_fetch;
    pmt_core_model_inst.fetch(1'b1, 12'h0a0);
    #1;
    check("loaded pc", 16'h0140, {3'h0, pc});
    fetch_check(16'h0f55, 13'h0142);
    fetch_check(16'h0000, 13'h0144);
    fetch_check(16'hc123, 13'h0146);
    fetch_check(16'hf456, 13'h0148);
    $display("Test fetch done");
  endtask : t_fetch

  // One odd byte rewritten; blank holding bytes leave their neighbours alone.
  task automatic t_modify;
    op(4'h8, 13'h0145, 8'h0f);
    op(4'h2, 13'h0145, 8'h00);
    run_ctrl(8'h09, 13'h0140, 8'h88, PROG);
    rd_check(13'h0145, 8'h01);
    rd_check(13'h0144, 8'h23);
    rd_check(13'h0147, 8'hf4);
    run_ctrl(8'h0d, 13'h0140, 8'h48, 0);
    rd_check(13'h0140, 8'h55);
    run_ctrl(8'h08, 13'h0140, 8'h08, 0);
    $display("Test modify done");
  endtask : t_modify

  // Erase of the block below leaves this one; erase at its last byte clears it.
  task automatic t_erase;
    run_ctrl(8'h0b, 13'h0100, 8'ha8, PROG);
    rd_check(13'h0140, 8'h55);
    run_ctrl(8'h0b, 13'h017f, 8'ha8, PROG);
    rd_check(13'h0140, 8'hff);
    rd_check(13'h0147, 8'hff);
    $display("Test erase done");
  endtask : t_erase

  // ---------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // The scenarios need well under a thousand cycles; five thousand marks a hang.
  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_program();
    t_fetch();
    t_modify();
    t_erase();
    complete_run();
  end
endmodule : program_memory_table_access_tb_top
